// >>> rtl/sdc_pkg.sv
// package: field layout, reset value and timing counts of the sense/dead-time register
`default_nettype none
package sdc_pkg;
    // --------------------------------------------------------------------
    // register layout
    // --------------------------------------------------------------------
    localparam int          REG_W          = 16;
    localparam logic [15:0] REG_RESET      = 16'h0000;
    localparam logic [15:0] REG_WMASK      = 16'hFF7F;
    localparam int          ANGLE_HI       = 15;
    localparam int          ANGLE_LO       = 14;
    localparam int          THR_HI         = 13;
    localparam int          THR_LO         = 10;
    localparam int          SCLK_HI        = 9;
    localparam int          SCLK_LO        = 8;
    localparam int          RSVD_BIT       = 7;
    localparam int          GAIN_HI        = 6;
    localparam int          GAIN_LO        = 5;
    localparam int          GAP_HI         = 4;
    localparam int          GAP_LO         = 0;

    // --------------------------------------------------------------------
    // decode constants
    // --------------------------------------------------------------------
    localparam logic [6:0]  ANGLE_STEP_DEG = 7'h1E;
    localparam logic [3:0]  THR_OFF        = 4'h0;
    localparam logic [3:0]  THR_ONE        = 4'h1;
    localparam logic [5:0]  THR_ONE_DECI_A = 6'h04;
    localparam logic [5:0]  THR_STEP_DECI_A = 6'h02;
    localparam logic [6:0]  RATE0_HZ       = 7'h0C;
    localparam logic [6:0]  RATE1_HZ       = 7'h18;
    localparam logic [6:0]  RATE2_HZ       = 7'h2F;
    localparam logic [6:0]  RATE3_HZ       = 7'h5F;

    // --------------------------------------------------------------------
    // timing
    // --------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 5;
    localparam int          RES0_NS        = 2560;
    localparam int          RES1_NS        = 1280;
    localparam int          RES2_NS        = 640;
    localparam int          RES3_NS        = 320;
    localparam logic [9:0]  RES0_CYC       = 10'(RES0_NS / CLK_PERIOD_NS);
    localparam logic [9:0]  RES1_CYC       = 10'(RES1_NS / CLK_PERIOD_NS);
    localparam logic [9:0]  RES2_CYC       = 10'(RES2_NS / CLK_PERIOD_NS);
    localparam logic [9:0]  RES3_CYC       = 10'(RES3_NS / CLK_PERIOD_NS);
    localparam int          GAP_STEP_NS    = 40;
    localparam logic [8:0]  GAP_STEP_CYC   = 9'(GAP_STEP_NS / CLK_PERIOD_NS);
endpackage : sdc_pkg
`default_nettype wire

// >>> rtl/sdc_startup_cfg.sv
// module: start-up sense and driver dead-time configuration register
`default_nettype none
module sdc_startup_cfg
    import sdc_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    rst_b,
    input  wire logic                    host_wr_en,
    input  wire logic [sdc_pkg::REG_W-1:0] host_wr_data,
    output logic      [sdc_pkg::REG_W-1:0] host_rd_data,
    output logic      [1:0]              post_sense_advance_angle,
    output logic      [6:0]              advance_angle_deg,
    output logic                         inductive_position_detect_en,
    output logic                         align_and_go,
    output logic      [3:0]              sense_current_threshold,
    output logic      [5:0]              threshold_deci_amp,
    output logic      [1:0]              sense_clock_select,
    output logic      [6:0]              sense_rate_hz,
    output logic      [9:0]              sense_res_cycles,
    output logic      [1:0]              loop_gain_constant,
    output logic      [2:0]              loop_gain_quarters,
    output logic      [4:0]              driver_gap_time,
    output logic      [8:0]              driver_gap_cycles
);
    import sdc_pkg::*;

    // --------------------------------------------------------------------
    // register storage
    // --------------------------------------------------------------------
    logic [REG_W-1:0] cfg_r;
    logic [REG_W-1:0] cfg_nxt;

    always_comb
    begin
        cfg_nxt = cfg_r;
        if (host_wr_en)
        begin
            cfg_nxt = host_wr_data & REG_WMASK;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_r <= REG_RESET;
        end
        else
        begin
            cfg_r <= cfg_nxt;
        end
    end

    assign host_rd_data             = cfg_r;
    assign post_sense_advance_angle = cfg_r[ANGLE_HI:ANGLE_LO];
    assign sense_current_threshold  = cfg_r[THR_HI:THR_LO];
    assign sense_clock_select       = cfg_r[SCLK_HI:SCLK_LO];
    assign loop_gain_constant       = cfg_r[GAIN_HI:GAIN_LO];
    assign driver_gap_time          = cfg_r[GAP_HI:GAP_LO];

    // --------------------------------------------------------------------
    // angle and gain decode
    // --------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            advance_angle_deg  <= ANGLE_STEP_DEG;
            loop_gain_quarters <= 3'h1;
        end
        else
        begin
            advance_angle_deg  <= 7'(ANGLE_STEP_DEG * ({5'h00, post_sense_advance_angle} + 7'h01));
            loop_gain_quarters <= {1'b0, loop_gain_constant} + 3'h1;
        end
    end

    // --------------------------------------------------------------------
    // sense threshold decode
    // --------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            inductive_position_detect_en <= 1'b0;
            align_and_go                 <= 1'b1;
            threshold_deci_amp           <= 6'h00;
        end
        else
        begin
            inductive_position_detect_en <= (sense_current_threshold != THR_OFF);
            align_and_go                 <= (sense_current_threshold == THR_OFF);
            if (sense_current_threshold == THR_OFF)
            begin
                threshold_deci_amp <= 6'h00;
            end
            else if (sense_current_threshold == THR_ONE)
            begin
                threshold_deci_amp <= THR_ONE_DECI_A;
            end
            else
            begin
                threshold_deci_amp <= 6'(THR_STEP_DECI_A * ({2'h0, sense_current_threshold} + 6'h01));
            end
        end
    end

    // --------------------------------------------------------------------
    // sense clock decode
    // --------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sense_rate_hz    <= RATE0_HZ;
            sense_res_cycles <= RES0_CYC;
        end
        else
        begin
            unique case (sense_clock_select)
                2'h0:
                begin
                    sense_rate_hz    <= RATE0_HZ;
                    sense_res_cycles <= RES0_CYC;
                end
                2'h1:
                begin
                    sense_rate_hz    <= RATE1_HZ;
                    sense_res_cycles <= RES1_CYC;
                end
                2'h2:
                begin
                    sense_rate_hz    <= RATE2_HZ;
                    sense_res_cycles <= RES2_CYC;
                end
                2'h3:
                begin
                    sense_rate_hz    <= RATE3_HZ;
                    sense_res_cycles <= RES3_CYC;
                end
            endcase
        end
    end

    // --------------------------------------------------------------------
    // dead time decode
    // --------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            driver_gap_cycles <= GAP_STEP_CYC;
        end
        else
        begin
            driver_gap_cycles <= 9'(GAP_STEP_CYC * ({4'h0, driver_gap_time} + 9'h001));
        end
    end

    // --------------------------------------------------------------------
    // checks
    // --------------------------------------------------------------------
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    property p_angle;
        post_sense_advance_angle == 2'h3 ##1 post_sense_advance_angle == 2'h3
            |-> advance_angle_deg == 7'h78;
    endproperty
    a_angle: assert property (p_angle) else $error("advance angle not 120");

    property p_skip;
        ##1 1'b1 |-> inductive_position_detect_en == ($past(sense_current_threshold) != 4'h0)
            && align_and_go == ($past(sense_current_threshold) == 4'h0);
    endproperty
    a_skip: assert property (p_skip) else $error("sense skip decode wrong");

    property p_thr_one;
        sense_current_threshold == 4'h1 |=> threshold_deci_amp == 6'h04;
    endproperty
    a_thr_one: assert property (p_thr_one) else $error("threshold one not 0.4 A");

    property p_thr_n;
        sense_current_threshold == 4'hF |=> threshold_deci_amp == 6'h20;
    endproperty
    a_thr_n: assert property (p_thr_n) else $error("threshold 15 not 3.2 A");

    property p_sclk;
        sense_clock_select == 2'h0 |=> sense_rate_hz == 7'h0C && sense_res_cycles == 10'h200;
    endproperty
    a_sclk: assert property (p_sclk) else $error("sense clock code 0 decode wrong");

    property p_rsvd;
        host_wr_en |=> host_rd_data[7] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");

    property p_gain;
        loop_gain_constant == 2'h2 |=> loop_gain_quarters == 3'h3;
    endproperty
    a_gain: assert property (p_gain) else $error("loop gain 0.75 decode wrong");

    property p_gap;
        driver_gap_time == 5'h1F |=> driver_gap_cycles == 9'h100;
    endproperty
    a_gap: assert property (p_gap) else $error("dead time max decode wrong");

    property p_write;
        host_wr_en |=> host_rd_data == ($past(host_wr_data) & 16'hFF7F);
    endproperty
    a_write: assert property (p_write) else $error("written value not read back");

    property p_hold;
        !host_wr_en |=> $stable(host_rd_data);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without write");
endmodule : sdc_startup_cfg
`default_nettype wire

// >>> dv/sdc_host_model.sv
// host model: drives register writes on the falling edge
`default_nettype none
module sdc_host_model
    import sdc_pkg::*;
(
    input  wire logic                      clk_sys,
    output logic                           host_wr_en,
    output logic      [sdc_pkg::REG_W-1:0] host_wr_data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        host_wr_en   = 1'b0;
        host_wr_data = 16'h0000;
    end

    // one write; strobe stays up when another follows
    task automatic wr(input logic [15:0] d, input bit rsvd_hit, input bit more);
        @(negedge clk_sys);
        host_wr_en   = 1'b1;
        host_wr_data = rsvd_hit ? d : {d[15:8], 1'b0, d[6:0]};
        @(posedge clk_sys);
        if (!more)
        begin
            @(negedge clk_sys);
            host_wr_en   = 1'b0;
            host_wr_data = ~host_wr_data;
        end
    endtask : wr
endmodule : sdc_host_model
`default_nettype wire

// >>> dv/test_startup_sense_config_reg.sv
// testbench: queued expectations against register and decoded outputs
`default_nettype none
module test_startup_sense_config_reg;
    timeunit 1ns;
    timeprecision 100ps;
    import sdc_pkg::*;

    logic        clk_sys = 1'b0;
    logic        rst_b   = 1'b0;
    logic        host_wr_en;
    logic [15:0] host_wr_data, host_rd_data;
    logic [1:0]  post_sense_advance_angle, sense_clock_select, loop_gain_constant;
    logic [6:0]  advance_angle_deg, sense_rate_hz;
    logic        inductive_position_detect_en, align_and_go;
    logic [3:0]  sense_current_threshold;
    logic [5:0]  threshold_deci_amp;
    logic [9:0]  sense_res_cycles;
    logic [2:0]  loop_gain_quarters;
    logic [4:0]  driver_gap_time;
    logic [8:0]  driver_gap_cycles;
    logic        v1 = 1'b0;
    logic        v2 = 1'b0;
    logic [63:0] exp_q[$];
    logic [63:0] last;
    int          err_total = 0;
    int          checks    = 0;
    int          cycles    = 0;
    localparam logic [6:0] RATES[4] = '{7'h0C, 7'h18, 7'h2F, 7'h5F};

    wire logic [30:0] raw_seen = {host_rd_data, post_sense_advance_angle,
        sense_current_threshold, sense_clock_select, loop_gain_constant, driver_gap_time};
    wire logic [43:0] dec_seen = {advance_angle_deg, inductive_position_detect_en,
        align_and_go, threshold_deci_amp, sense_rate_hz, sense_res_cycles,
        loop_gain_quarters, driver_gap_cycles};

    always #2.5 clk_sys = ~clk_sys;

    sdc_startup_cfg dut (.clk_sys(clk_sys), .rst_b(rst_b), .host_wr_en(host_wr_en),
        .host_wr_data(host_wr_data), .host_rd_data(host_rd_data),
        .post_sense_advance_angle(post_sense_advance_angle),
        .advance_angle_deg(advance_angle_deg),
        .inductive_position_detect_en(inductive_position_detect_en),
        .align_and_go(align_and_go), .sense_current_threshold(sense_current_threshold),
        .threshold_deci_amp(threshold_deci_amp), .sense_clock_select(sense_clock_select),
        .sense_rate_hz(sense_rate_hz), .sense_res_cycles(sense_res_cycles),
        .loop_gain_constant(loop_gain_constant), .loop_gain_quarters(loop_gain_quarters),
        .driver_gap_time(driver_gap_time), .driver_gap_cycles(driver_gap_cycles));

    sdc_host_model host (.clk_sys(clk_sys), .host_wr_en(host_wr_en),
        .host_wr_data(host_wr_data));

    // register word on top, decoded values below
    function automatic logic [63:0] expect_of(input logic [15:0] d);
        logic [15:0] r;
        logic [5:0]  deci;
        r    = {d[15:8], 1'b0, d[6:0]};
        deci = (r[13:10] == 4'h0) ? 6'h00 : (r[13:10] == 4'h1) ? 6'h04
             : 6'(2 * (int'(r[13:10]) + 1));
        return {4'h0, r, 7'(30 * (int'(r[15:14]) + 1)), r[13:10] != 4'h0,
                r[13:10] == 4'h0, deci, RATES[r[9:8]], 10'(512 >> r[9:8]),
                3'(int'(r[6:5]) + 1), 9'(8 * (int'(r[4:0]) + 1))};
    endfunction : expect_of

    function automatic logic [63:0] raw_of(input logic [63:0] e);
        return {33'h0, e[59:44], e[59:52], e[50:44]};
    endfunction : raw_of

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    task automatic send(input logic [15:0] d, input bit rsvd_hit, input bit more);
        last = expect_of(rsvd_hit ? d : {d[15:8], 1'b0, d[6:0]});
        exp_q.push_back(last);
        host.wr(d, rsvd_hit, more);
    endtask : send

    task automatic check_reset();
        check(64'(raw_seen), 64'h0);
        check(64'(dec_seen), 64'(44'(expect_of(16'h0000))));
    endtask : check_reset

    // monitor: raw one edge after a write, decoded one edge later
    always @(posedge clk_sys)
    begin
        v1 <= host_wr_en & rst_b;
        v2 <= v1;
        cycles++;
        if (cycles == 2000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    always @(negedge clk_sys)
    begin
        if (v1)
            check(64'(raw_seen), raw_of(exp_q[v2 ? 1 : 0]));
        if (v2)
            check(64'(dec_seen), 64'(44'(exp_q.pop_front())));
    end

    initial
    begin
        void'($urandom(32'h3BE5));
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        check_reset();
        rst_b = 1'b1;
        for (int i = 0; i < 16; i++)
            send({i[1:0], i[3:0], i[1:0], 1'b1, i[1:0], 5'($urandom)}, i[0], 1'b1);
        send(16'hFFFF, 1'b1, 1'b0);
        send(16'h0000, 1'b1, 1'b0);
        for (int i = 0; i < 40; i++)
            send(16'($urandom), 1'b1, i != 39);
        repeat (20) @(negedge clk_sys);
        check(64'(raw_seen), raw_of(last));
        rst_b = 1'b0;
        @(negedge clk_sys);
        check_reset();
        rst_b = 1'b1;
        send(16'($urandom), 1'b0, 1'b0);
        repeat (4) @(negedge clk_sys);
        tally_and_finish();
    end
endmodule : test_startup_sense_config_reg
`default_nettype wire
